// File: common/scr_pkg.sv
// Shared constants for the supervisor call and resume unit.
// Assumes a processor core that decodes instructions and owns memory.
package scr_pkg;
	// Address width of instruction and operand pointers
	localparam int ADDR_W         = 18;
	// Address-mode codes
	localparam logic [1:0] AMODE_2CH = 2'h1;
	localparam logic [1:0] AMODE_3CH = 2'h0;
	localparam logic [1:0] AMODE_4CH = 2'h3;
	// Indicator word layout: trap, amode[1:0], ovf, zero, le, eq
	localparam int IND_W          = 7;
	localparam int IND_TRAP       = 6;
	localparam int IND_AMODE_HI   = 5;
	localparam int IND_AMODE_LO   = 4;
	localparam int IND_OVF        = 3;
	localparam int IND_ZERO       = 2;
	localparam int IND_LE         = 1;
	localparam int IND_EQ         = 0;
	localparam logic [6:0] IND_RESET = 7'h00;
	// Source indicator layout
	localparam int SRC_W          = 4;
	localparam int SRC_ADRV       = 3;
	localparam int SRC_SVC        = 2;
	localparam int SRC_PANEL      = 1;
	localparam int SRC_PERIPH     = 0;
	localparam logic [3:0] SRC_RESET = 4'h0;
	// Resume operand formats
	typedef enum logic [1:0] {
		FMT_FULL,
		FMT_AONLY,
		FMT_NONE
	} scr_fmt_e;
	// AHB register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_IP     = 8'h08;
	localparam logic [7:0] OFF_EXTLNK = 8'h0C;
	localparam logic [7:0] OFF_INTLNK = 8'h10;
	localparam logic [7:0] OFF_AOP    = 8'h14;
	localparam logic [7:0] OFF_BOP    = 8'h18;
	localparam logic [7:0] OFF_IND    = 8'h1C;
	// Control register bits (write-only strobes / levels)
	localparam int CTRL_SVC       = 0;
	localparam int CTRL_RESUME    = 1;
	localparam int CTRL_FMT_LO    = 2;
	localparam int CTRL_FMT_HI    = 3;
	localparam int CTRL_CLRSRC    = 4;
	// Status register: internal mode bit, writable so software can enter it
	localparam int STAT_INT       = 5;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// File: rtl/scr_ahb_slave.sv
// AHB-Lite slave front end: captures address phase, issues a write
// strobe in the data phase; reads are decoded in scr_unit. Zero wait states.
// Assumes a single master, word transfers only.
`timescale 1ns/1ps
module scr_ahb_slave (
	input  wire logic        clk,        // Core clock
	input  wire logic        arst_n,     // Async reset, low
	input  wire logic        hsel,       // Slave select
	input  wire logic [31:0] haddr,      // Byte address
	input  wire logic [1:0]  htrans,     // Transfer type
	input  wire logic        hwrite,     // Write when high
	input  wire logic        hready,     // Bus ready in
	input  wire logic [31:0] hwdata,     // Write data
	output logic             wrStb,      // Write strobe, one cycle
	output logic [7:0]       regAddr,    // Latched offset
	output logic [31:0]      wrData      // Write data passthrough
);
	logic       wrPend_r;
	logic [7:0] addr_r;
	wire        take = hsel && hready && (htrans == scr_pkg::HTRANS_NONSEQ);

	// Latch address phase
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wrPend_r <= 1'b0;
			addr_r   <= 8'h00;
		end else if (hready) begin
			wrPend_r <= take && hwrite;
			addr_r   <= take ? haddr[7:0] : addr_r;
		end
	end

	assign wrStb   = wrPend_r;
	assign regAddr = addr_r;
	assign wrData  = hwdata;
endmodule

// File: rtl/scr_unit.sv
// Supervisor call and resume unit with register view over AHB-Lite.
// Assumes the core reports the next-instruction address and executes
// one instruction at a time; memory and word marks live elsewhere.
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module scr_unit #(
	parameter int AW = scr_pkg::ADDR_W    // Address width
) (
	input  wire logic          clk,        // Core clock, 100 MHz
	input  wire logic          arst_n,     // Async reset, low
	input  wire logic          svcOp,      // Supervisor call executes
	input  wire logic          resumeOp,   // Resume executes
	input  wire logic [1:0]    resumeFmt,  // Resume operand format
	input  wire logic [AW-1:0] nextAddr,   // Address of next instruction
	input  wire logic [AW-1:0] opAddrA,    // A field of resume
	input  wire logic [AW-1:0] opAddrB,    // B field of resume
	input  wire logic          hsel,       // AHB select
	input  wire logic [31:0]   haddr,      // AHB address
	input  wire logic [1:0]    htrans,     // AHB transfer type
	input  wire logic          hwrite,     // AHB write
	input  wire logic [2:0]    hsize,      // AHB size, word only
	input  wire logic          hready,     // AHB ready in
	input  wire logic [31:0]   hwdata,     // AHB write data
	output logic [31:0]        hrdata,     // AHB read data
	output logic               hreadyout,  // AHB ready out
	output logic               hresp,      // AHB response
	output logic               extMode,    // External interrupt mode
	output logic               intMode,    // Internal interrupt mode
	output logic [AW-1:0]      instrPtr,   // Instruction pointer
	output logic [AW-1:0]      aOpPtr,     // A operand pointer
	output logic [AW-1:0]      bOpPtr,     // B operand pointer
	output logic [6:0]         indicators, // Live indicators
	output logic [3:0]         srcInd      // Interrupt source flags
);
	localparam logic [AW-1:0] ZERO_A = '0;

	logic          extMode_r, intMode_r;
	logic [AW-1:0] ip_r, extLnk_r, intLnk_r, aOp_r, bOp_r;
	logic [6:0]    ind_r, aux_r;
	logic [3:0]    src_r;
	logic [31:0]   rdata_r;
	logic          wrStb;
	logic [7:0]    regAddr;
	logic [31:0]   wrData;

	// Bus front end
	scr_ahb_slave u_bus (
		.clk     (clk),
		.arst_n  (arst_n),
		.hsel    (hsel),
		.haddr   (haddr),
		.htrans  (htrans),
		.hwrite  (hwrite),
		.hready  (hready),
		.hwdata  (hwdata),
		.wrStb   (wrStb),
		.regAddr (regAddr),
		.wrData  (wrData)
	);

	// Software command strobes; the pin strobes are OR'd in
	wire ctlWr   = wrStb && (regAddr == scr_pkg::OFF_CTRL);
	wire swSvc   = ctlWr && wrData[scr_pkg::CTRL_SVC];
	wire swRes   = ctlWr && wrData[scr_pkg::CTRL_RESUME];
	wire swClr   = ctlWr && wrData[scr_pkg::CTRL_CLRSRC];
	wire doSvc   = (svcOp || swSvc) && !extMode_r;
	wire doRes   = (resumeOp || swRes) && !doSvc;
	wire [1:0] fmt = swRes ? wrData[scr_pkg::CTRL_FMT_HI:scr_pkg::CTRL_FMT_LO]
	                       : resumeFmt;
	// Next address: software-issued resume/call uses current pointer
	wire [AW-1:0] nxt = (swSvc || swRes) ? ip_r : nextAddr;
	wire resExt  = doRes && extMode_r;
	wire resInt  = doRes && !extMode_r && intMode_r;
	// Resume in standard mode only updates operand pointers
	wire loadA   = doRes && (fmt == scr_pkg::FMT_FULL ||
	                         fmt == scr_pkg::FMT_AONLY);
	wire loadB   = doRes && (fmt == scr_pkg::FMT_FULL);

	// Register writes from software
	wire wrIp  = wrStb && (regAddr == scr_pkg::OFF_IP);
	wire wrExt = wrStb && (regAddr == scr_pkg::OFF_EXTLNK);
	wire wrInt = wrStb && (regAddr == scr_pkg::OFF_INTLNK);
	wire wrInd = wrStb && (regAddr == scr_pkg::OFF_IND);
	wire wrSt  = wrStb && (regAddr == scr_pkg::OFF_STATUS);

	// Indicator after call: constant with all flags cleared, 3-char, no trap
	wire [6:0] svcInd = {1'b0, scr_pkg::AMODE_3CH, 4'h0};

	// Mode indicators
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			extMode_r <= 1'b0;
			intMode_r <= 1'b0;
		end else begin
			if (doSvc)
				extMode_r <= 1'b1;
			else if (resExt)
				extMode_r <= 1'b0;
			// Internal entry is software's job here; resume wins over it
			if (resInt)
				intMode_r <= 1'b0;
			else if (wrSt)
				intMode_r <= wrData[scr_pkg::STAT_INT];
		end
	end

	// Indicators and aux store
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ind_r <= scr_pkg::IND_RESET;
			aux_r <= scr_pkg::IND_RESET;
		end else if (doSvc) begin
			aux_r <= ind_r;
			ind_r <= svcInd;
		end else if (resExt) begin
			ind_r <= aux_r;
		end else if (wrInd) begin
			ind_r <= wrData[6:0];
		end
	end

	// Source flags: call sets its flag; set wins over clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			src_r <= scr_pkg::SRC_RESET;
		else if (doSvc)
			src_r <= 4'h1 << scr_pkg::SRC_SVC;
		else if (swClr)
			src_r <= scr_pkg::SRC_RESET;
	end

	// Pointer and return links; no memory write path exists at all
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ip_r     <= ZERO_A;
			extLnk_r <= ZERO_A;
			intLnk_r <= ZERO_A;
		end else if (doSvc) begin
			ip_r     <= extLnk_r;
			extLnk_r <= nxt;
		end else if (resExt) begin
			ip_r     <= extLnk_r;
			extLnk_r <= nxt;
		end else if (resInt) begin
			ip_r     <= intLnk_r;
			intLnk_r <= nxt;
		end else begin
			if (wrIp)
				ip_r <= wrData[AW-1:0];
			if (wrExt)
				extLnk_r <= wrData[AW-1:0];
			if (wrInt)
				intLnk_r <= wrData[AW-1:0];
		end
	end

	// Operand pointers per resume format
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aOp_r <= ZERO_A;
			bOp_r <= ZERO_A;
		end else begin
			if (loadA)
				aOp_r <= opAddrA;
			if (loadB)
				bOp_r <= opAddrB;
		end
	end

	// Read mux; unmapped reads return zero
	function automatic logic [31:0] padA(input logic [AW-1:0] v);
		padA = 32'(v);
	endfunction
	wire rdTake = hsel && hready && !hwrite &&
	              (htrans == scr_pkg::HTRANS_NONSEQ);
	logic [31:0] rdMux;
	always_comb begin
		case (haddr[7:0])
			scr_pkg::OFF_STATUS:
				rdMux = {22'h0, src_r, intMode_r, extMode_r,
				         aux_r[3:0]};
			scr_pkg::OFF_IP:     rdMux = padA(ip_r);
			scr_pkg::OFF_EXTLNK: rdMux = padA(extLnk_r);
			scr_pkg::OFF_INTLNK: rdMux = padA(intLnk_r);
			scr_pkg::OFF_AOP:    rdMux = padA(aOp_r);
			scr_pkg::OFF_BOP:    rdMux = padA(bOp_r);
			scr_pkg::OFF_IND:    rdMux = {18'h0, aux_r, ind_r};
			default:             rdMux = 32'h0000_0000;
		endcase
	end

	// Read data registered at end of address phase
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			rdata_r <= 32'h0000_0000;
		else if (rdTake)
			rdata_r <= rdMux;
	end

	assign hrdata     = rdata_r;
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign extMode    = extMode_r;
	assign intMode    = intMode_r;
	assign instrPtr   = ip_r;
	assign aOpPtr     = aOp_r;
	assign bOpPtr     = bOp_r;
	assign indicators = ind_r;
	assign srcInd     = src_r;

	// Checks
	sequence s_svc_taken;
		svcOp && !extMode_r;
	endsequence

	a_svc_enters_ext: assert property (@(posedge clk) disable iff (!arst_n)
		s_svc_taken |=> extMode_r)
		else $error("call did not enter external mode");
	a_svc_src_flag: assert property (@(posedge clk) disable iff (!arst_n)
		s_svc_taken |=> src_r[scr_pkg::SRC_SVC])
		else $error("call source flag not set");
	a_svc_saves_ind: assert property (@(posedge clk) disable iff (!arst_n)
		s_svc_taken |=> aux_r == $past(ind_r))
		else $error("indicators not saved");
	a_svc_clear_mode: assert property (@(posedge clk) disable iff (!arst_n)
		s_svc_taken |=> ind_r == 7'h00)
		else $error("call indicators not cleared to 3-char");
	a_svc_swap_link: assert property (@(posedge clk) disable iff (!arst_n)
		s_svc_taken |=> ip_r == $past(extLnk_r) && extLnk_r == $past(nxt))
		else $error("call pointer swap wrong");
	a_res_ext_off: assert property (@(posedge clk) disable iff (!arst_n)
		resExt |=> !extMode_r && ind_r == $past(aux_r))
		else $error("external resume wrong");
	a_res_int_swap: assert property (@(posedge clk) disable iff (!arst_n)
		resInt |=> !intMode_r && ip_r == $past(intLnk_r)
		           && intLnk_r == $past(nxt))
		else $error("internal resume wrong");
	a_res_fmt_b: assert property (@(posedge clk) disable iff (!arst_n)
		doRes && fmt == scr_pkg::FMT_AONLY |=> $stable(bOp_r)
		&& aOp_r == $past(opAddrA))
		else $error("A-only format wrong");
	a_res_fmt_c: assert property (@(posedge clk) disable iff (!arst_n)
		doRes && fmt == scr_pkg::FMT_NONE |=> $stable(aOp_r)
		&& $stable(bOp_r))
		else $error("no-operand format changed pointers");
	a_res_fmt_a: assert property (@(posedge clk) disable iff (!arst_n)
		doRes && fmt == scr_pkg::FMT_FULL |=> aOp_r == $past(opAddrA)
		&& bOp_r == $past(opAddrB))
		else $error("full format pointers wrong");
	a_res_ext_swap: assert property (@(posedge clk) disable iff (!arst_n)
		resExt |=> ip_r == $past(extLnk_r) && extLnk_r == $past(nxt))
		else $error("external resume swap wrong");
endmodule

// File: tb/supervisor_call_and_return_tb.sv
// Self-checking bench for the supervisor call and resume unit.
// Assumes scr_unit answers the bus with zero waits and registers outputs.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
	nErrors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module supervisor_call_and_return_tb;
	localparam int AW = scr_pkg::ADDR_W;
	typedef struct packed {
		logic [1:0]    fmt;
		logic [6:0]    ind;
		logic [AW-1:0] expA;
		logic [AW-1:0] expB;
	} scr_row_s;
	logic          clk;
	logic          arst_n;
	logic          svcOp;
	logic          resumeOp;
	logic [1:0]    resumeFmt;
	logic [AW-1:0] nextAddr;
	logic [AW-1:0] opAddrA;
	logic [AW-1:0] opAddrB;
	logic          hsel;
	logic [31:0]   haddr;
	logic [1:0]    htrans;
	logic          hwrite;
	logic [2:0]    hsize;
	logic [31:0]   hwdata;
	logic [31:0]   hrdata;
	logic [31:0]   rd;
	logic          hreadyout;
	logic          hresp;
	logic          extMode;
	logic          intMode;
	logic [AW-1:0] instrPtr;
	logic [AW-1:0] aOpPtr;
	logic [AW-1:0] bOpPtr;
	logic [6:0]    indicators;
	logic [3:0]    srcInd;
	wire           hready = hreadyout;
	int            nErrors = 0;
	int            checked = 0;
	// One row per resume format; indicator words cover all mode codes
	scr_row_s rows [3] = '{
		'{scr_pkg::FMT_FULL,  7'h5F, 18'h1_2345, 18'h2_3456},
		'{scr_pkg::FMT_AONLY, 7'h3A, 18'h1_2346, 18'h2_3456},
		'{scr_pkg::FMT_NONE,  7'h4F, 18'h1_2346, 18'h2_3456}};

	scr_unit #(.AW(AW)) scr_unit_i (
		.clk(clk), .arst_n(arst_n), .svcOp(svcOp), .resumeOp(resumeOp),
		.resumeFmt(resumeFmt), .nextAddr(nextAddr), .opAddrA(opAddrA),
		.opAddrB(opAddrB), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.extMode(extMode), .intMode(intMode), .instrPtr(instrPtr),
		.aOpPtr(aOpPtr), .bOpPtr(bOpPtr), .indicators(indicators),
		.srcInd(srcInd));

	// Free-running core clock, 100 MHz
	initial clk = 1'b0;
	always #5 clk = ~clk;

	task automatic end_sim;
		$display("Errors %0d, checks %0d", nErrors, checked);
		if (nErrors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Bounded wait for ready; a hung bus ends the run as a failure
	task automatic waitRdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (n >= 20) begin
			nErrors++;
			end_sim();
		end
	endtask

	// Single word transfer; read data is taken at the data-phase edge
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= scr_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		waitRdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		waitRdy();
		rd = hrdata;
	endtask

	// One-cycle op pulse, then let the state settle before looking
	task automatic op(input logic s, input logic r, input logic [1:0] f,
			input logic [AW-1:0] nx, input logic [AW-1:0] a,
			input logic [AW-1:0] b);
		svcOp <= s;
		resumeOp <= r;
		resumeFmt <= f;
		nextAddr <= nx;
		opAddrA <= a;
		opAddrB <= b;
		@(posedge clk);
		svcOp <= 1'b0;
		resumeOp <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	// Main sequence: reset, row loop, then the awkward cases
	initial begin
		arst_n = 1'b0;
		svcOp = 1'b0;
		resumeOp = 1'b0;
		resumeFmt = 2'h0;
		nextAddr = '0;
		opAddrA = '0;
		opAddrB = '0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		#1;
		`CHK("extMode", 1'b0, extMode)
		`CHK("intMode", 1'b0, intMode)
		`CHK("hresp", 1'b0, hresp)
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, scr_pkg::OFF_IND, {25'h0, rows[k].ind});
			bus(1'b1, scr_pkg::OFF_AOP, 32'h0000_0AAA);
			bus(1'b1, scr_pkg::OFF_BOP, 32'h0000_0BBB);
			bus(1'b1, scr_pkg::OFF_EXTLNK, 32'h0000_0100 + k);
			op(1'b1, 1'b0, 2'h0, 18'h0_2000 + 18'(k), '0, '0);
			`CHK("extMode", 1'b1, extMode)
			`CHK("srcInd", 4'h4, srcInd)
			`CHK("arith", 3'h0, indicators[3:1])
			`CHK("amode", scr_pkg::AMODE_3CH, indicators[5:4])
			`CHK("trap", 1'b0, indicators[6])
			`CHK("instrPtr", 18'h0_0100 + 18'(k), instrPtr)
			bus(1'b0, scr_pkg::OFF_EXTLNK, 32'h0000_0000);
			`CHK("extLink", 32'h0000_2000 + k, rd)
			bus(1'b0, scr_pkg::OFF_IND, 32'h0000_0000);
			`CHK("aux", rows[k].ind, rd[13:7])
			bus(1'b0, scr_pkg::OFF_STATUS, 32'h0000_0000);
			`CHK("srcRead", 4'h4, rd[9:6])
			op(1'b0, 1'b1, rows[k].fmt, 18'h0_3000 + 18'(k),
				18'h1_2345 + 18'(k), 18'h2_3456 + 18'(k));
			`CHK("extMode", 1'b0, extMode)
			`CHK("ind", rows[k].ind, indicators)
			`CHK("aOpPtr", rows[k].expA, aOpPtr)
			`CHK("bOpPtr", rows[k].expB, bOpPtr)
			`CHK("instrPtr", 18'h0_2000 + 18'(k), instrPtr)
			bus(1'b0, scr_pkg::OFF_EXTLNK, 32'h0000_0000);
			`CHK("extLink", 32'h0000_3000 + k, rd)
		end
		// A second call inside external mode must leave the link alone
		bus(1'b1, scr_pkg::OFF_EXTLNK, 32'h0000_0400);
		op(1'b1, 1'b0, 2'h0, 18'h0_0500, '0, '0);
		op(1'b1, 1'b0, 2'h0, 18'h3_FFFF, '0, '0);
		`CHK("instrPtr", 18'h0_0400, instrPtr)
		bus(1'b0, scr_pkg::OFF_EXTLNK, 32'h0000_0000);
		`CHK("extLink", 32'h0000_0500, rd)
		bus(1'b1, scr_pkg::OFF_CTRL, 32'h0000_0010);
		#1;
		`CHK("srcClr", 4'h0, srcInd)
		op(1'b0, 1'b1, scr_pkg::FMT_NONE, 18'h0_0600, '0, '0);
		`CHK("extMode", 1'b0, extMode)
		// Resume in standard mode only moves the operand pointers
		bus(1'b1, scr_pkg::OFF_IP, 32'h0000_0700);
		op(1'b0, 1'b1, scr_pkg::FMT_FULL, 18'h0_0800, 18'h0_0011,
			18'h0_0022);
		`CHK("instrPtr", 18'h0_0700, instrPtr)
		`CHK("aOpPtr", 18'h0_0011, aOpPtr)
		// Internal mode entered through the status view
		bus(1'b1, scr_pkg::OFF_INTLNK, 32'h0000_0900);
		bus(1'b1, scr_pkg::OFF_STATUS, 32'h0000_0020);
		#1;
		`CHK("intMode", 1'b1, intMode)
		op(1'b0, 1'b1, scr_pkg::FMT_AONLY, 18'h0_0A00, 18'h0_0033,
			18'h0_0044);
		`CHK("intMode", 1'b0, intMode)
		`CHK("instrPtr", 18'h0_0900, instrPtr)
		`CHK("bOpPtr", 18'h0_0022, bOpPtr)
		bus(1'b0, scr_pkg::OFF_INTLNK, 32'h0000_0000);
		`CHK("intLink", 32'h0000_0A00, rd)
		// Reset in mid-run must drop internal mode and the pointer
		bus(1'b1, scr_pkg::OFF_STATUS, 32'h0000_0020);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		#1;
		`CHK("intMode", 1'b0, intMode)
		`CHK("instrPtr", 18'h0_0000, instrPtr)
		// Unmapped place: write is dropped, read gives zero
		bus(1'b1, 8'h40, 32'hDEAD_BEEF);
		bus(1'b0, 8'h40, 32'h0000_0000);
		`CHK("unmapped", 32'h0000_0000, rd)
		end_sim();
	end
endmodule
